/* File: design/dmlc_consts.vh */
// constants of the multi-purpose line control block
`ifndef DMLC_CONSTS_VH
`define DMLC_CONSTS_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define DMLC_IDX_LINE0_AVAIL   30'h0000_B86A
`define DMLC_IDX_LINE1_AVAIL   30'h0000_B86B
`define DMLC_IDX_LINE2_AVAIL   30'h0000_B86C
`define DMLC_IDX_LINE0_GEN     30'h0000_B860
`define DMLC_IDX_LINE1_GEN     30'h0000_B861
`define DMLC_IDX_LINE2_GEN     30'h0000_B862
`define DMLC_IDX_LINE0_SYNTH   30'h0009_470B
`define DMLC_IDX_LINE1_SYNTH   30'h0009_470C
`define DMLC_IDX_LINE2_SYNTH   30'h0009_470D
`define DMLC_IDX_MANUAL        30'h0009_470E
`define DMLC_IDX_STATUS        30'h0009_4710

// ****************************************
// general mode codes and available mask
// ****************************************
`define DMLC_GEN_LINE_OFF      32'h0000_0001
`define DMLC_GEN_SYNTH_MODE    32'h0000_0004
`define DMLC_AVAIL_MODES       32'h0000_0005
`define DMLC_GEN_RESET         32'h0000_0001

// ****************************************
// synthesis-specific mode codes
// ****************************************
`define DMLC_SYN_OFF           2'h0
`define DMLC_SYN_MANUAL        2'h1
`define DMLC_SYN_ARMED         2'h2
`define DMLC_SYN_EXEC          2'h3
`define DMLC_SYN_RESET         2'h0

// ****************************************
// manual level bits
// ****************************************
`define DMLC_MAN_LINE0_BIT     0
`define DMLC_MAN_LINE1_BIT     1
`define DMLC_MAN_LINE2_BIT     2
`define DMLC_MAN_RESET         3'h0

// ****************************************
// timing
// ****************************************
`define DMLC_CLK_PERIOD_PS     20000
`define DMLC_TICK_PS           6400
`define DMLC_TICK_RAW          ((`DMLC_TICK_PS + `DMLC_CLK_PERIOD_PS - 1) / `DMLC_CLK_PERIOD_PS)
`define DMLC_TICK_CYC          ((`DMLC_TICK_RAW < 1) ? 1 : `DMLC_TICK_RAW)

`endif

/* File: design/dmlc_line.v */
// one multi-purpose line driven by the synthesis engine
`default_nettype none
`include "dmlc_consts.vh"

module dmlc_line (
    input  wire       core_clk_in,
    input  wire       reset_n_in,
    input  wire       synth_sel_in,
    input  wire [1:0] synth_mode_in,
    input  wire       manual_bit_in,
    input  wire       manual_exec_in,
    input  wire       armed_in,
    input  wire       load_in,
    output reg        line_q_out
);

    localparam integer PULSE_INT = `DMLC_TICK_CYC;
    localparam [7:0]   PULSE_CYC = PULSE_INT[7:0];

    reg        level_q;
    reg [7:0]  pulse_cnt_q;
    reg        line_d;

    // ****************************************
    // manual level and execute pulse
    // ****************************************
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            level_q     <= 1'b0;
            pulse_cnt_q <= 8'h00;
        end else begin
            if (manual_exec_in) begin
                level_q <= manual_bit_in;
            end
            if (load_in) begin
                pulse_cnt_q <= PULSE_CYC;
            end else if (pulse_cnt_q != 8'h00) begin
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
            end
        end
    end

    // ****************************************
    // output select
    // ****************************************
    always @* begin
        line_d = 1'b0;
        if (synth_sel_in) begin
            case (synth_mode_in)
                `DMLC_SYN_MANUAL: line_d = manual_exec_in ? manual_bit_in : level_q;
                `DMLC_SYN_ARMED:  line_d = armed_in;
                `DMLC_SYN_EXEC:   line_d = load_in | (pulse_cnt_q > 8'h01);
                default:          line_d = 1'b0;
            endcase
        end
    end

    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            line_q_out <= 1'b0;
        end else begin
            line_q_out <= line_d;
        end
    end

endmodule // dmlc_line
`default_nettype wire

/* File: design/dmlc_top.v */
// multi-purpose line control: ahb-lite registers and three engine-driven lines
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`default_nettype none
`include "dmlc_consts.vh"

module dmlc_top (
    input  wire        core_clk_in,
    input  wire        reset_n_in,
    // ahb-lite slave
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire        hready_in,
    input  wire [31:0] hwdata_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    // synthesis engine
    input  wire        engine_armed_in,
    input  wire        engine_load_in,
    // lines
    output wire        line_zero_out,
    output wire        line_one_out,
    output wire        line_two_out
);

    // ****************************************
    // bus state
    // ****************************************
    reg        wr_pend_q;
    reg        rd_pend_q;
    reg [29:0] addr_q;

    wire       addr_phase;
    wire       wr_accept;
    wire       rd_accept;

    // ****************************************
    // register storage
    // ****************************************
    reg [31:0] gen_mode_q [0:2];
    reg [1:0]  synth_mode_q [0:2];
    reg [2:0]  manual_pend_q;
    reg        manual_valid_q;

    wire [2:0] line_level;
    wire [2:0] synth_sel;
    wire       manual_exec;

    // ****************************************
    // decode helpers
    // ****************************************
    wire       hit_manual;
    wire       gen_code_ok;

    // ****************************************
    // read mux
    // ****************************************
    reg [31:0] rd_data_d;

    assign addr_phase = hsel_in & htrans_in[1] & hready_in;
    assign wr_accept  = addr_phase & hwrite_in;
    assign rd_accept  = addr_phase & ~hwrite_in;

    assign hit_manual = wr_pend_q & (addr_q == `DMLC_IDX_MANUAL);

    // one-hot and available only
    assign gen_code_ok = ((hwdata_in & (hwdata_in - 32'h0000_0001)) == 32'h0000_0000)
                       & (hwdata_in != 32'h0000_0000)
                       & ((hwdata_in & ~`DMLC_AVAIL_MODES) == 32'h0000_0000);

    // queued manual command runs with the engine load
    assign manual_exec = engine_load_in & manual_valid_q;

    // ****************************************
    // ahb-lite address and data phases
    // ****************************************
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            wr_pend_q     <= 1'b0;
            rd_pend_q     <= 1'b0;
            addr_q        <= 30'h0000_0000;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hresp_out <= 1'b0;
            if (rd_pend_q) begin
                hrdata_out    <= rd_data_d;
                hreadyout_out <= 1'b1;
                rd_pend_q     <= 1'b0;
            end else if (addr_phase) begin
                addr_q        <= haddr_in[31:2];
                rd_pend_q     <= rd_accept;
                hreadyout_out <= ~rd_accept;
            end
            if (addr_phase) begin
                wr_pend_q <= wr_accept;
            end else if (hready_in) begin
                wr_pend_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // per-line mode registers
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_line_regs
            wire [31:0] gen_sum;
            wire [31:0] syn_sum;
            wire [29:0] gen_idx;
            wire [29:0] syn_idx;
            assign gen_sum = `DMLC_IDX_LINE0_GEN + gi;
            assign syn_sum = `DMLC_IDX_LINE0_SYNTH + gi;
            assign gen_idx = gen_sum[29:0];
            assign syn_idx = syn_sum[29:0];

            always @(posedge core_clk_in) begin
                if (!reset_n_in) begin
                    gen_mode_q[gi]   <= `DMLC_GEN_RESET;
                    synth_mode_q[gi] <= `DMLC_SYN_RESET;
                end else if (wr_pend_q) begin
                    if ((addr_q == gen_idx) && gen_code_ok) begin
                        gen_mode_q[gi] <= hwdata_in;
                    end
                    if (addr_q == syn_idx) begin
                        synth_mode_q[gi] <= hwdata_in[1:0];
                    end
                end
            end

            // synthesis mode only acts once the line is handed over
            assign synth_sel[gi] = (gen_mode_q[gi] == `DMLC_GEN_SYNTH_MODE);

            dmlc_line u_line (
                .core_clk_in    (core_clk_in),
                .reset_n_in     (reset_n_in),
                .synth_sel_in   (synth_sel[gi]),
                .synth_mode_in  (synth_mode_q[gi]),
                .manual_bit_in  (manual_pend_q[gi]),
                .manual_exec_in (manual_exec),
                .armed_in       (engine_armed_in),
                .load_in        (engine_load_in),
                .line_q_out     (line_level[gi])
            );
        end
    endgenerate

    // ****************************************
    // manual command queue
    // ****************************************
    always @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            manual_pend_q  <= `DMLC_MAN_RESET;
            manual_valid_q <= 1'b0;
        end else begin
            if (hit_manual) begin
                manual_pend_q[`DMLC_MAN_LINE0_BIT] <= hwdata_in[`DMLC_MAN_LINE0_BIT];
                manual_pend_q[`DMLC_MAN_LINE1_BIT] <= hwdata_in[`DMLC_MAN_LINE1_BIT];
                manual_pend_q[`DMLC_MAN_LINE2_BIT] <= hwdata_in[`DMLC_MAN_LINE2_BIT];
                manual_valid_q <= 1'b1;
            end else if (manual_exec) begin
                manual_valid_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // read data select
    // ****************************************
    always @* begin
        rd_data_d = 32'h0000_0000;
        case (addr_q)
            `DMLC_IDX_LINE0_AVAIL: rd_data_d = `DMLC_AVAIL_MODES;
            `DMLC_IDX_LINE1_AVAIL: rd_data_d = `DMLC_AVAIL_MODES;
            `DMLC_IDX_LINE2_AVAIL: rd_data_d = `DMLC_AVAIL_MODES;
            `DMLC_IDX_LINE0_GEN:   rd_data_d = gen_mode_q[0];
            `DMLC_IDX_LINE1_GEN:   rd_data_d = gen_mode_q[1];
            `DMLC_IDX_LINE2_GEN:   rd_data_d = gen_mode_q[2];
            `DMLC_IDX_LINE0_SYNTH: rd_data_d = {30'h0000_0000, synth_mode_q[0]};
            `DMLC_IDX_LINE1_SYNTH: rd_data_d = {30'h0000_0000, synth_mode_q[1]};
            `DMLC_IDX_LINE2_SYNTH: rd_data_d = {30'h0000_0000, synth_mode_q[2]};
            `DMLC_IDX_STATUS:      rd_data_d = {24'h00_0000, manual_valid_q, engine_armed_in,
                                                synth_sel[1:0] == 2'b00 ? 1'b0 : 1'b1,
                                                synth_sel[2], line_level[2:0], 1'b0};
            default:               rd_data_d = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // line outputs
    // ****************************************
    assign line_zero_out = line_level[0];
    assign line_one_out  = line_level[1];
    assign line_two_out  = line_level[2];

endmodule // dmlc_top
`default_nettype wire

/* File: tb/dmlc_chk.sv */
// assertion checker for the multi-purpose line control block
`default_nettype none
`include "dmlc_consts.vh"
module dmlc_chk (
    input wire logic        core_clk_in,
    input wire logic        reset_n_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic        hready_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    input wire logic        engine_armed_in,
    input wire logic        engine_load_in,
    input wire logic        line_zero_out,
    input wire logic        line_two_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic        wr_q;
    logic        on_q;
    logic [1:0]  syn_q;
    logic [29:0] wa_q;
    wire         take = hsel_in & htrans_in[1] & hready_in;
    wire         man  = on_q && syn_q == `DMLC_SYN_MANUAL;
    wire         exe  = on_q && syn_q == `DMLC_SYN_EXEC;
    // ****************************************
    // shadow of line zero mode registers
    // ****************************************
    always_ff @(posedge core_clk_in) begin
        wa_q <= haddr_in[31:2];
        if (!reset_n_in) begin
            wr_q  <= 1'b0;
            on_q  <= 1'b0;
            syn_q <= `DMLC_SYN_RESET;
        end else begin
            wr_q <= take & hwrite_in;
            if (wr_q && wa_q == `DMLC_IDX_LINE0_GEN && (hwdata_in == 32'h0000_0001 || hwdata_in == 32'h0000_0004))
                on_q <= hwdata_in == `DMLC_GEN_SYNTH_MODE;
            if (wr_q && wa_q == `DMLC_IDX_LINE0_SYNTH)
                syn_q <= hwdata_in[1:0];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    property p_rd_wait; take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_fast; take && hwrite_in |=> hreadyout_out; endproperty
    a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
    property p_okay; take |=> !hresp_out [*2]; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_off; !on_q |=> !line_zero_out; endproperty
    a_off: assert property (p_off) else $error("line driven while not handed over");
    property p_armed; on_q && syn_q == `DMLC_SYN_ARMED |=> line_zero_out == $past(engine_armed_in); endproperty
    a_armed: assert property (p_armed) else $error("armed indication wrong");
    property p_exec_hi; exe && engine_load_in |=> line_zero_out; endproperty
    a_exec_hi: assert property (p_exec_hi) else $error("execute pulse missing");
    property p_exec_lo; exe && !engine_load_in |=> !line_zero_out; endproperty
    a_exec_lo: assert property (p_exec_lo) else $error("execute pulse too long");
    property p_hold; man && $past(man) && !engine_load_in |=> $stable(line_zero_out); endproperty
    a_hold: assert property (p_hold) else $error("manual level not held");
    property p_rise; $rose(line_two_out) |-> $past(engine_load_in) || $past(engine_armed_in); endproperty
    a_rise: assert property (p_rise) else $error("line rose without cause");
endmodule // dmlc_chk
`default_nettype wire

/* File: tb/dmlc_equip.sv */
// external equipment model: counts rising edges seen on the three lines
`default_nettype none
module dmlc_equip (
    input  wire logic       core_clk_in,
    input  wire logic [2:0] lines_in,
    output var  logic [7:0] rise_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] last_q = 3'h0;
    initial rise_cnt_out = 8'h00;
    always @(posedge core_clk_in) begin
        last_q <= lines_in;
        rise_cnt_out <= rise_cnt_out + 8'($countones(lines_in & ~last_q));
    end
endmodule // dmlc_equip
`default_nettype wire

/* File: tb/tb.sv */
// testbench for the multi-purpose line control block
`default_nettype none
`include "dmlc_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic        armed = 1'b0;
    logic        load = 1'b0;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
    logic [2:0]  lines;
    logic [7:0]  rise_cnt;
    logic [31:0] rd;
    int          mismatches = 0;
    int          n_compared = 0;
    always #10 clk = ~clk;
    dmlc_top dmlc_top_i (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .engine_armed_in(armed),
        .engine_load_in(load), .line_zero_out(lines[0]), .line_one_out(lines[1]), .line_two_out(lines[2]));
    dmlc_equip dmlc_equip_i (.core_clk_in(clk), .lines_in(lines), .rise_cnt_out(rise_cnt));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {idx, 2'b00};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic setall(input logic [29:0] base, input logic [31:0] v);
        for (int i = 0; i < 3; i++) bus(1'b1, base + 30'(i), v);
    endtask
    task automatic drive(input logic ld, input logic arm, input logic [2:0] exp);
        @(posedge clk);
        load <= ld;
        armed <= arm;
        @(posedge clk);
        load <= 1'b0;
        #1;
        chk({29'h0, lines}, {29'h0, exp});
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #50000;
        mismatches++;
        $display("[ERR] %0t: run hung", $time);
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b1, `DMLC_IDX_LINE0_AVAIL, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, `DMLC_IDX_LINE0_AVAIL + 30'(i), 32'h0);
            chk(rd, `DMLC_AVAIL_MODES);
            bus(1'b0, `DMLC_IDX_LINE0_GEN + 30'(i), 32'h0);
            chk(rd, `DMLC_GEN_RESET);
            bus(1'b0, `DMLC_IDX_LINE0_SYNTH + 30'(i), 32'h0);
            chk(rd, {30'h0, `DMLC_SYN_RESET});
        end
        bus(1'b0, 30'h0000_0001, 32'h0);
        chk(rd, 32'h0000_0000);
        $display("test registers done");
        setall(`DMLC_IDX_LINE0_GEN, `DMLC_GEN_SYNTH_MODE);
        bus(1'b1, `DMLC_IDX_LINE1_GEN, 32'h0000_0005);
        bus(1'b0, `DMLC_IDX_LINE1_GEN, 32'h0);
        chk(rd, `DMLC_GEN_SYNTH_MODE);
        bus(1'b1, `DMLC_IDX_LINE2_GEN, `DMLC_GEN_LINE_OFF);
        bus(1'b0, `DMLC_IDX_LINE2_GEN, 32'h0);
        chk(rd, `DMLC_GEN_LINE_OFF);
        bus(1'b1, `DMLC_IDX_LINE2_GEN, `DMLC_GEN_SYNTH_MODE);
        setall(`DMLC_IDX_LINE0_SYNTH, 32'h0000_0003);
        bus(1'b0, `DMLC_IDX_LINE2_SYNTH, 32'h0);
        chk(rd, 32'h0000_0003);
        drive(1'b1, 1'b0, 3'b111);
        drive(1'b0, 1'b0, 3'b000);
        chk({24'h0, rise_cnt}, 32'h0000_0003);
        $display("test execute done");
        setall(`DMLC_IDX_LINE0_SYNTH, 32'h0000_0001);
        bus(1'b1, `DMLC_IDX_MANUAL, 32'h0000_0005);
        bus(1'b0, `DMLC_IDX_MANUAL, 32'h0);
        chk(rd, 32'h0000_0000);
        drive(1'b0, 1'b0, 3'b000);
        drive(1'b1, 1'b0, 3'b101);
        bus(1'b1, `DMLC_IDX_MANUAL, 32'h0000_0002);
        drive(1'b1, 1'b0, 3'b010);
        drive(1'b0, 1'b0, 3'b010);
        $display("test manual done");
        setall(`DMLC_IDX_LINE0_SYNTH, 32'h0000_0002);
        drive(1'b0, 1'b1, 3'b111);
        drive(1'b0, 1'b0, 3'b000);
        bus(1'b1, `DMLC_IDX_LINE0_GEN, `DMLC_GEN_LINE_OFF);
        drive(1'b0, 1'b1, 3'b110);
        drive(1'b0, 1'b0, 3'b000);
        bus(1'b0, `DMLC_IDX_STATUS, 32'h0);
        chk(rd, 32'h0000_0030);
        $display("test armed done");
        report_and_stop;
    end
endmodule // tb
bind dmlc_top dmlc_chk dmlc_chk_i (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hready_in(hready_in),
    .hwdata_in(hwdata_in), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .engine_armed_in(engine_armed_in), .engine_load_in(engine_load_in), .line_zero_out(line_zero_out),
    .line_two_out(line_two_out));
`default_nettype wire
